// ### src/rdsc_pkg.sv
/*
  shared constants and types of the redundancy device switch control:
  transfer steps, display codes, backup input points, timing figures.
  assumes a 25 MHz core clock.
*/
package rdsc_pkg;

  localparam int CLK_KHZ = 25000;

  // maximum scan times, in ms, and their cycle counts
  localparam int SCAN_SHORT_MS = 150;
  localparam int SCAN_LONG_MS = 250;
  localparam int SCAN_SHORT_CYC = SCAN_SHORT_MS * CLK_KHZ;
  localparam int SCAN_LONG_CYC = SCAN_LONG_MS * CLK_KHZ;

  // half period of the flashing display, in ms
  localparam int FLASH_MS = 250;
  localparam int FLASH_CYC = FLASH_MS * CLK_KHZ;

  localparam int RELAY_COUNT = 12;

  // register numbers moved by the transfers
  localparam logic [15:0] RETURN_REG = 16'h00FE;
  localparam logic [15:0] FULL_FIRST_REG = 16'h0001;
  localparam logic [15:0] FULL_LAST_REG = 16'h1000;

  // backup indication input points
  localparam logic [10:0] DEFAULT_BACKUP_INPUT = 11'h400;
  localparam logic [10:0] ALTERNATE_BACKUP_INPUT = 11'h3FE;

  // status digit values
  localparam logic [3:0] DIG_HUNG_BUS = 4'h4;
  localparam logic [3:0] DIG_STORAGE = 4'h5;
  localparam logic [3:0] DIG_PROGRAM = 4'h6;
  localparam logic [3:0] DIG_DATA_CTRL = 4'h7;
  localparam logic [3:0] DIG_SELF = 4'h8;
  localparam logic [3:0] DIG_CPU_SWITCH = 4'h9;

  // transfer steps, walked in this order
  localparam logic [2:0] STEP_INPUT = 3'h0;
  localparam logic [2:0] STEP_TIMEBASE = 3'h1;
  localparam logic [2:0] STEP_OUTPUT = 3'h2;
  localparam logic [2:0] STEP_TRANSITION = 3'h3;
  localparam logic [2:0] STEP_OVERRIDE = 3'h4;
  localparam logic [2:0] STEP_FULL_REGS = 3'h5;
  localparam logic [2:0] STEP_RANGE = 3'h6;
  localparam logic [2:0] STEP_RETURN = 3'h7;
  localparam logic [2:0] STEP_LAST = 3'h7;

  typedef enum logic [2:0] {
    XK_INPUT,
    XK_TIMEBASE,
    XK_OUTPUT,
    XK_TRANSITION,
    XK_OVERRIDE,
    XK_REGS
  } rdsc_kind_e;

endpackage

// ### src/rdsc_seg_enc.sv
/*
  seven segment encoder for the status digit, with blanking.
  assumes segments gfedcba, active high, and a digit of 0..9.
*/
`timescale 1ns/1ps
module rdsc_seg_enc (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] digit,
  input wire logic blank,
  output logic [6:0] seg
);

  function automatic logic [6:0] encode(input logic [3:0] d);
    logic [6:0] s;
    s = 7'h00;
    unique case (d)
      4'h0: s = 7'h3F;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5B;
      4'h3: s = 7'h4F;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6D;
      4'h6: s = 7'h7D;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7F;
      4'h9: s = 7'h6F;
      default: s = 7'h40;
    endcase
    return s;
  endfunction

  wire logic [6:0] nxt_seg;
  assign nxt_seg = blank ? 7'h00 : encode(digit);

  logic [6:0] seg_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seg_ff <= 7'h00;
    end else begin
      seg_ff <= nxt_seg;
    end
  end
  assign seg = seg_ff;

endmodule

// ### src/rdsc_ctrl.sv
/*
  redundancy device switch control: relay changeover, master lamps,
  per-sweep and backup-entry transfer sequencing, backup input point,
  scan watchdog and status display.
  assumes sweep and backup-entry pulses and fault flags come from logic
  on clk; master select, run/hold and processor fail are pins.
*/
// Functional notes
// RL1: return option copies register 254 backup to master every sweep
// RL2: range option copies master registers start..end to backup per sweep
// RL3: output table option copies outputs and transitions each sweep
// RL4: full init on backup entry copies 4096 registers and all tables
// RL5: without full init, entry copies only option-chosen and default data
// RL6: backup indication on input 1024, or 1022 when alternate selected
// RL7: scan limit 150 ms by default, 250 ms when selected
// RL8: inputs and timer time base copied to backup every sweep
// RL9: each transfer option may also be set by master table bits
// RL10: first lamp lit for CPU1 master, second for CPU2 master
// RL11: normal digit 0..3 from redundant and auxiliary chain configuration
// RL12: error digits 4..9 for the six fault sources
// RL13: display flashes after the watchdog expires
// RL14: hold, processor failure or errors 5..9 stop kicking the watchdog; code reads the shown digit, so a hung bus (4) masks them
// RL15: relays rest on normally closed contacts when bus is CPU1
// RL16: relays energised onto normally open contacts when bus is CPU2
// RL17: twelve changeover relays switched together by master selection
// RL18: one transfer sequence at a time; sweeps during one are deferred
`timescale 1ns/1ps
module rdsc_ctrl #(
  parameter int RELAYS = rdsc_pkg::RELAY_COUNT,
  parameter int SCAN_SHORT_CYC = rdsc_pkg::SCAN_SHORT_CYC,
  parameter int SCAN_LONG_CYC = rdsc_pkg::SCAN_LONG_CYC,
  parameter int FLASH_CYC = rdsc_pkg::FLASH_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cpu2Select,
  input wire logic runHoldHold,
  input wire logic processorFail,
  input wire logic sweepTick,
  input wire logic backupEntry,
  input wire logic backupReturnCopyOpt,
  input wire logic registerRangeCopy,
  input wire logic outputTableCopy,
  input wire logic fullBackupInit,
  input wire logic [3:0] tableOptBits,
  input wire logic backupBitSelect,
  input wire logic scanLimitSelect,
  input wire logic [15:0] rangeStartReg,
  input wire logic [15:0] rangeEndReg,
  input wire logic xferAck,
  input wire logic redundantChains,
  input wire logic auxChain,
  input wire logic hungBus,
  input wire logic storageFault,
  input wire logic programFault,
  input wire logic dataCtrlFault,
  input wire logic selfFault,
  input wire logic cpuSwitchFault,
  output logic [RELAYS-1:0] relayCoil,
  output logic cpu1Lamp,
  output logic cpu2Lamp,
  output logic xferReq,
  output rdsc_pkg::rdsc_kind_e xferKind,
  output logic xferFromBackup,
  output logic [15:0] xferFirst,
  output logic [15:0] xferLast,
  output logic xferBusy,
  output logic [10:0] backupPoint,
  output logic watchdogExpired,
  output logic [3:0] statusDigit,
  output logic [6:0] statusSeg
);

  initial begin
    if (RELAYS != 12) $error("relay count must be 12");
    if (SCAN_SHORT_CYC < 2 || SCAN_LONG_CYC < SCAN_SHORT_CYC)
      $error("scan limits out of range");
    if (FLASH_CYC < 1) $error("flash period out of range");
  end

  // pin synchronisers
  logic [2:0] pinMeta_ff;
  logic [2:0] pinSync_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta_ff <= 3'h0;
      pinSync_ff <= 3'h0;
    end else begin
      pinMeta_ff <= {processorFail, runHoldHold, cpu2Select};
      pinSync_ff <= pinMeta_ff;
    end
  end
  wire logic cpu2Master;
  wire logic holdSync;
  wire logic failSync;
  assign cpu2Master = pinSync_ff[0];
  assign holdSync = pinSync_ff[1];
  assign failSync = pinSync_ff[2];

  // relays and lamps
  logic [RELAYS-1:0] relay_ff;
  logic [1:0] lamp_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      relay_ff <= '0;
      lamp_ff <= 2'h0;
    end else begin
      relay_ff <= {RELAYS{cpu2Master}}; // RL15 RL16 RL17
      lamp_ff <= {cpu2Master, ~cpu2Master}; // RL10
    end
  end
  assign relayCoil = relay_ff;
  assign cpu1Lamp = lamp_ff[0];
  assign cpu2Lamp = lamp_ff[1];

  // effective options: jumper or master table bit
  wire logic optReturn;
  wire logic optRange;
  wire logic optOutput;
  wire logic optFull;
  assign optReturn = backupReturnCopyOpt | tableOptBits[0]; // RL9
  assign optRange = registerRangeCopy | tableOptBits[1]; // RL9
  assign optOutput = outputTableCopy | tableOptBits[2]; // RL9
  assign optFull = fullBackupInit | tableOptBits[3]; // RL9

  // transfer sequencer
  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_SEEK,
    SQ_WAIT
  } rdsc_seq_e;

  rdsc_seq_e state_ff;
  logic [2:0] step_ff;
  logic initRun_ff;
  logic sweepPend_ff;
  logic entryPend_ff;
  logic req_ff;
  rdsc_pkg::rdsc_kind_e kind_ff;
  logic fromBackup_ff;
  logic [15:0] first_ff;
  logic [15:0] last_ff;

  // whether a step runs in this sequence
  function automatic logic stepOn(input logic [2:0] s, input logic full);
    logic on;
    on = 1'b0;
    unique case (s)
      rdsc_pkg::STEP_INPUT: on = 1'b1; // RL8
      rdsc_pkg::STEP_TIMEBASE: on = 1'b1; // RL8
      rdsc_pkg::STEP_OUTPUT: on = optOutput | full; // RL3 RL4
      rdsc_pkg::STEP_TRANSITION: on = optOutput | full; // RL3 RL4
      rdsc_pkg::STEP_OVERRIDE: on = full; // RL4 RL5
      rdsc_pkg::STEP_FULL_REGS: on = full; // RL4 RL5
      rdsc_pkg::STEP_RANGE: on = optRange && (rangeEndReg >= rangeStartReg);
      rdsc_pkg::STEP_RETURN: on = optReturn; // RL1
    endcase
    return on;
  endfunction

  function automatic rdsc_pkg::rdsc_kind_e stepKind(input logic [2:0] s);
    rdsc_pkg::rdsc_kind_e k;
    k = rdsc_pkg::XK_REGS;
    unique case (s)
      rdsc_pkg::STEP_INPUT: k = rdsc_pkg::XK_INPUT;
      rdsc_pkg::STEP_TIMEBASE: k = rdsc_pkg::XK_TIMEBASE;
      rdsc_pkg::STEP_OUTPUT: k = rdsc_pkg::XK_OUTPUT;
      rdsc_pkg::STEP_TRANSITION: k = rdsc_pkg::XK_TRANSITION;
      rdsc_pkg::STEP_OVERRIDE: k = rdsc_pkg::XK_OVERRIDE;
      default: k = rdsc_pkg::XK_REGS;
    endcase
    return k;
  endfunction

  wire logic fullNow;
  wire logic stepEnabled;
  wire logic lastStep;
  wire logic startAny;
  wire logic startInit;
  wire logic [15:0] stepFirst;
  wire logic [15:0] stepLast;
  assign fullNow = initRun_ff & optFull;
  assign stepEnabled = stepOn(step_ff, fullNow);
  assign lastStep = (step_ff == rdsc_pkg::STEP_LAST);
  // entry beats sweep: a fresh backup must be initialised first
  assign startInit = entryPend_ff | backupEntry;
  assign startAny = startInit | sweepPend_ff | sweepTick;
  assign stepFirst = (step_ff == rdsc_pkg::STEP_FULL_REGS) ?
    rdsc_pkg::FULL_FIRST_REG : (step_ff == rdsc_pkg::STEP_RANGE) ?
    rangeStartReg : rdsc_pkg::RETURN_REG; // RL1 RL2 RL4
  assign stepLast = (step_ff == rdsc_pkg::STEP_FULL_REGS) ?
    rdsc_pkg::FULL_LAST_REG : (step_ff == rdsc_pkg::STEP_RANGE) ?
    rangeEndReg : rdsc_pkg::RETURN_REG; // RL1 RL2 RL4

  rdsc_seq_e nxt_state;
  logic [2:0] nxt_step;
  logic nxt_initRun;
  logic nxt_req;
  logic nxt_sweepPend;
  logic nxt_entryPend;
  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_initRun = initRun_ff;
    nxt_req = req_ff;
    // set wins over consumption: a tick in the launch cycle stays pending
    nxt_sweepPend = sweepPend_ff | sweepTick; // RL18
    nxt_entryPend = entryPend_ff | backupEntry; // RL18
    unique case (state_ff)
      SQ_IDLE: begin
        if (startAny) begin
          nxt_state = SQ_SEEK;
          nxt_step = rdsc_pkg::STEP_INPUT;
          nxt_initRun = startInit;
          // consume the older request; a fresh pulse this cycle stays
          if (startInit) begin
            nxt_entryPend = entryPend_ff & backupEntry; // RL18
          end else begin
            nxt_sweepPend = sweepPend_ff & sweepTick; // RL18
          end
        end
      end
      SQ_SEEK: begin
        if (stepEnabled) begin
          nxt_req = 1'b1;
          nxt_state = SQ_WAIT;
        end else if (lastStep) begin
          nxt_state = SQ_IDLE;
        end else begin
          nxt_step = step_ff + 3'h1;
        end
      end
      SQ_WAIT: begin
        if (xferAck) begin
          nxt_req = 1'b0;
          if (lastStep) begin
            nxt_state = SQ_IDLE;
          end else begin
            nxt_state = SQ_SEEK;
            nxt_step = step_ff + 3'h1;
          end
        end
      end
    endcase
  end

  wire logic loadCmd;
  assign loadCmd = (state_ff == SQ_SEEK) && stepEnabled;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= SQ_IDLE;
      step_ff <= rdsc_pkg::STEP_INPUT;
      initRun_ff <= 1'b0;
      req_ff <= 1'b0;
      sweepPend_ff <= 1'b0;
      entryPend_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      initRun_ff <= nxt_initRun;
      req_ff <= nxt_req;
      sweepPend_ff <= nxt_sweepPend;
      entryPend_ff <= nxt_entryPend;
    end
  end

  // command words, held for the whole request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kind_ff <= rdsc_pkg::XK_INPUT;
      fromBackup_ff <= 1'b0;
      first_ff <= 16'h0000;
      last_ff <= 16'h0000;
    end else if (loadCmd) begin
      kind_ff <= stepKind(step_ff);
      fromBackup_ff <= (step_ff == rdsc_pkg::STEP_RETURN); // RL1
      first_ff <= stepFirst; // RL2
      last_ff <= stepLast; // RL2
    end
  end

  assign xferReq = req_ff;
  assign xferKind = kind_ff;
  assign xferFromBackup = fromBackup_ff;
  assign xferFirst = first_ff;
  assign xferLast = last_ff;
  assign xferBusy = (state_ff != SQ_IDLE); // RL18

  // backup indication point
  logic [10:0] point_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      point_ff <= rdsc_pkg::DEFAULT_BACKUP_INPUT;
    end else begin
      point_ff <= backupBitSelect ? rdsc_pkg::ALTERNATE_BACKUP_INPUT :
        rdsc_pkg::DEFAULT_BACKUP_INPUT; // RL6
    end
  end
  assign backupPoint = point_ff;

  // status digit: lowest error code wins, else configuration
  logic [3:0] digit;
  always_comb begin
    if (hungBus) begin
      digit = rdsc_pkg::DIG_HUNG_BUS; // RL12
    end else if (storageFault) begin
      digit = rdsc_pkg::DIG_STORAGE; // RL12
    end else if (programFault) begin
      digit = rdsc_pkg::DIG_PROGRAM; // RL12
    end else if (dataCtrlFault) begin
      digit = rdsc_pkg::DIG_DATA_CTRL; // RL12
    end else if (selfFault) begin
      digit = rdsc_pkg::DIG_SELF; // RL12
    end else if (cpuSwitchFault) begin
      digit = rdsc_pkg::DIG_CPU_SWITCH; // RL12
    end else begin
      digit = {2'b00, auxChain, redundantChains}; // RL11
    end
  end

  logic [3:0] digit_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      digit_ff <= 4'h0;
    end else begin
      digit_ff <= digit;
    end
  end
  assign statusDigit = digit_ff;

  // watchdog on the sweep; the limit follows the scan selection
  wire logic errLatch;
  wire logic kick;
  wire logic [31:0] scanLimit;
  assign errLatch = (digit_ff >= rdsc_pkg::DIG_STORAGE); // RL14
  assign kick = sweepTick & ~holdSync & ~failSync & ~errLatch; // RL14
  assign scanLimit = scanLimitSelect ? 32'(SCAN_LONG_CYC) :
    32'(SCAN_SHORT_CYC); // RL7

  logic [31:0] wdCnt_ff;
  logic wdExp_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdCnt_ff <= 32'h0000_0000;
      wdExp_ff <= 1'b0;
    end else begin
      if (kick) begin
        wdCnt_ff <= 32'h0000_0000;
      end else if (!wdExp_ff) begin
        wdCnt_ff <= wdCnt_ff + 32'h0000_0001;
      end
      // latched: a tripped unit needs a reset to recover
      if (!kick && wdCnt_ff >= scanLimit - 32'h0000_0001) begin
        wdExp_ff <= 1'b1; // RL7 RL14
      end
    end
  end
  assign watchdogExpired = wdExp_ff;

  // flash phase
  logic [31:0] flashCnt_ff;
  logic flashOff_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flashCnt_ff <= 32'h0000_0000;
      flashOff_ff <= 1'b0;
    end else if (!wdExp_ff) begin
      flashCnt_ff <= 32'h0000_0000;
      flashOff_ff <= 1'b0;
    end else if (flashCnt_ff == 32'(FLASH_CYC - 1)) begin
      flashCnt_ff <= 32'h0000_0000;
      flashOff_ff <= ~flashOff_ff; // RL13
    end else begin
      flashCnt_ff <= flashCnt_ff + 32'h0000_0001;
    end
  end

  rdsc_seg_enc u_seg (
    .clk(clk),
    .nrst(nrst),
    .digit(digit_ff),
    .blank(flashOff_ff), // RL13
    .seg(statusSeg)
  );

endmodule

// ### verification/rdsc_ctrl_sva.sv
/*
  port assertions of rdsc_ctrl, bound into every instance.
  assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
module rdsc_ctrl_sva #(
  parameter int RELAYS = 12,
  parameter int FLASH_CYC = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cpu2Select,
  input wire logic sweepTick,
  input wire logic backupBitSelect,
  input wire logic xferAck,
  input wire logic [RELAYS-1:0] relayCoil,
  input wire logic cpu1Lamp,
  input wire logic cpu2Lamp,
  input wire logic xferReq,
  input wire rdsc_pkg::rdsc_kind_e xferKind,
  input wire logic xferFromBackup,
  input wire logic [15:0] xferFirst,
  input wire logic [15:0] xferLast,
  input wire logic xferBusy,
  input wire logic [10:0] backupPoint,
  input wire logic watchdogExpired,
  input wire logic [6:0] statusSeg
);
  logic [6:0] segPrev_ff;
  int segHold_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // a counter, since a flash phase is far longer than a repetition allows
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      segPrev_ff <= 7'h00;
      segHold_ff <= 0;
    end else begin
      segPrev_ff <= statusSeg;
      segHold_ff <= (watchdogExpired && statusSeg == segPrev_ff) ?
        segHold_ff + 1 : 0;
    end
  end
  sequence s_idleSweep;
    sweepTick && !xferBusy;
  endsequence
  sequence s_inputReq;
    ##[1:3] xferReq && xferKind == rdsc_pkg::XK_INPUT;
  endsequence
  chk_relay_gang:
    assert property (relayCoil == {RELAYS{cpu2Lamp}})
    else $error("relays not switched together with the lamp");
  chk_lamp_pair:
    assert property ($past(nrst, 2) |-> cpu1Lamp != cpu2Lamp)
    else $error("master lamps not complementary");
  chk_lamp_follow:
    assert property ($rose(cpu2Select) |-> ##[2:4] cpu2Lamp)
    else $error("second lamp late after select");
  chk_point_select:
    assert property ($past(nrst) && $stable(backupBitSelect) |->
      backupPoint == (backupBitSelect ? rdsc_pkg::ALTERNATE_BACKUP_INPUT :
      rdsc_pkg::DEFAULT_BACKUP_INPUT))
    else $error("backup input point wrong");
  chk_req_hold:
    assert property (xferReq && !xferAck |=> xferReq && $stable(xferKind)
      && $stable(xferFirst) && $stable(xferLast))
    else $error("request changed before its acknowledge");
  chk_req_drop:
    assert property (xferAck |=> !xferReq)
    else $error("request kept after acknowledge");
  chk_sweep_launch:
    assert property (s_idleSweep |-> s_inputReq)
    else $error("sweep did not begin with the input table");
  chk_return_regs:
    assert property (xferReq && xferFromBackup |->
      xferKind == rdsc_pkg::XK_REGS && xferFirst == rdsc_pkg::RETURN_REG
      && xferLast == rdsc_pkg::RETURN_REG)
    else $error("return copy not limited to its register");
  chk_wdog_sticky:
    assert property (watchdogExpired |=> watchdogExpired)
    else $error("watchdog expiry cleared without reset");
  chk_flash_rate:
    assert property (segHold_ff <= FLASH_CYC + 2)
    else $error("display not flashing after expiry");
endmodule

bind rdsc_ctrl rdsc_ctrl_sva #(.RELAYS(RELAYS), .FLASH_CYC(FLASH_CYC))
  u_rdsc_ctrl_sva (.clk, .nrst, .cpu2Select, .sweepTick, .backupBitSelect,
  .xferAck, .relayCoil, .cpu1Lamp, .cpu2Lamp, .xferReq, .xferKind,
  .xferFromBackup, .xferFirst, .xferLast, .xferBusy, .backupPoint,
  .watchdogExpired, .statusSeg);

// ### verification/rdsc_xfer_engine.sv
/*
  transfer engine model that answers the sequencer's requests.
  assumes a request holds until the cycle after its acknowledge.
*/
`timescale 1ns/1ps
module rdsc_xfer_engine (
  input wire logic clk,
  input wire logic nrst,
  input wire logic xferReq,
  input wire logic [3:0] ackDelay,
  output logic xferAck
);
  logic [3:0] waitCnt_ff;
  // one pulse per request; never answers while idle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitCnt_ff <= 4'h0;
      xferAck <= 1'h0;
    end else if (!xferReq || xferAck) begin
      waitCnt_ff <= 4'h0;
      xferAck <= 1'h0;
    end else if (waitCnt_ff == ackDelay) begin
      xferAck <= 1'h1;
    end else begin
      waitCnt_ff <= waitCnt_ff + 4'h1;
    end
  end
endmodule

// ### verification/redundancy_device_switch_ctrl_tb.sv
/*
  self-checking bench of rdsc_ctrl with the transfer engine model.
  assumes short watchdog and flash counts given by parameter.
*/
`timescale 1ns/1ps
module redundancy_device_switch_ctrl_tb;
  localparam logic [35:0] IN = {rdsc_pkg::XK_INPUT, 33'h0};
  localparam logic [35:0] TB = {rdsc_pkg::XK_TIMEBASE, 33'h0};
  localparam logic [35:0] OT = {rdsc_pkg::XK_OUTPUT, 33'h0};
  localparam logic [35:0] TR = {rdsc_pkg::XK_TRANSITION, 33'h0};
  localparam logic [35:0] OV = {rdsc_pkg::XK_OVERRIDE, 33'h0};
  localparam logic [35:0] RNG = {rdsc_pkg::XK_REGS, 33'h0000A0014};
  localparam logic [35:0] RET = {rdsc_pkg::XK_REGS, 1'h1,
    rdsc_pkg::RETURN_REG, rdsc_pkg::RETURN_REG};
  localparam logic [35:0] FULL = {rdsc_pkg::XK_REGS, 1'h0,
    rdsc_pkg::FULL_FIRST_REG, rdsc_pkg::FULL_LAST_REG};
  localparam logic [6:0] SEG [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
    7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
  logic clk, nrst, cpu2Select, runHoldHold, processorFail, sweepTick;
  logic backupEntry, backupBitSelect, scanLimitSelect, redundantChains;
  logic auxChain, xferAck, cpu1Lamp, cpu2Lamp, xferReq, xferFromBackup;
  logic xferBusy, watchdogExpired;
  logic [3:0] opts, tableOptBits, ackDelay, statusDigit;
  logic [5:0] faults;
  logic [15:0] rangeStartReg, rangeEndReg, xferFirst, xferLast;
  logic [11:0] relayCoil;
  logic [10:0] backupPoint;
  logic [6:0] statusSeg;
  rdsc_pkg::rdsc_kind_e xferKind;
  logic [35:0] got [$];
  int fails, samplesChecked;

  rdsc_ctrl #(.SCAN_SHORT_CYC(40), .SCAN_LONG_CYC(60), .FLASH_CYC(4))
    u_rdsc_ctrl (.clk, .nrst, .cpu2Select, .runHoldHold, .processorFail,
    .sweepTick, .backupEntry, .backupReturnCopyOpt(opts[0]),
    .registerRangeCopy(opts[1]), .outputTableCopy(opts[2]),
    .fullBackupInit(opts[3]), .tableOptBits, .backupBitSelect,
    .scanLimitSelect, .rangeStartReg, .rangeEndReg, .xferAck,
    .redundantChains, .auxChain, .hungBus(faults[0]),
    .storageFault(faults[1]), .programFault(faults[2]),
    .dataCtrlFault(faults[3]), .selfFault(faults[4]),
    .cpuSwitchFault(faults[5]), .relayCoil, .cpu1Lamp, .cpu2Lamp, .xferReq,
    .xferKind, .xferFromBackup, .xferFirst, .xferLast, .xferBusy,
    .backupPoint, .watchdogExpired, .statusDigit, .statusSeg);
  rdsc_xfer_engine u_rdsc_xfer_engine (.clk, .nrst, .xferReq, .ackDelay,
    .xferAck);

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // register numbers only mean something for register kinds
  always @(posedge clk)
    if (xferAck === 1'h1 && xferReq === 1'h1)
      got.push_back(xferKind == rdsc_pkg::XK_REGS ?
        {xferKind, xferFromBackup, xferFirst, xferLast} :
        {xferKind, xferFromBackup, 32'h0});

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic ok, input string what);
    samplesChecked++;
    if (ok !== 1'h1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic do_reset();
    nrst = 1'h0;
    cyc(10);
    nrst = 1'h1;
  endtask

  // busy may dip for a cycle between a sequence and a deferred one
  task automatic run(input logic s, input logic e, input int gap,
      input logic [35:0] exp [$]);
    int idle;
    got.delete();
    {sweepTick, backupEntry} = {s, e};
    cyc(1);
    {sweepTick, backupEntry} = 2'h0;
    if (gap > 0) begin
      cyc(gap);
      sweepTick = 1'h1;
      cyc(1);
      sweepTick = 1'h0;
    end
    idle = 0;
    for (int i = 0; i < 600 && idle < 3; i++) begin
      cyc(1);
      idle = (xferBusy === 1'h0) ? idle + 1 : 0;
    end
    chk(got.size() == exp.size(), "transfer count");
    foreach (exp[i]) chk(got.size() > i && got[i] === exp[i], "transfer");
  endtask

  task automatic wd(input logic [3:0] mode, input int n, input logic exp);
    logic [1:0] seen;
    {processorFail, scanLimitSelect, faults[1], runHoldHold} = mode;
    do_reset();
    for (int i = 0; i < n; i++) begin
      sweepTick = (i % 20 == 10);
      cyc(1);
    end
    sweepTick = 1'h0;
    chk(watchdogExpired === exp, "watchdog state");
    seen = 2'h0;
    repeat (12) begin
      cyc(1);
      seen = seen | {statusSeg != 7'h00, statusSeg == 7'h00};
    end
    if (exp) chk(seen === 2'h3, "display flash");
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {nrst, cpu2Select, runHoldHold, processorFail, sweepTick} = 5'h00;
    {backupEntry, backupBitSelect, scanLimitSelect, auxChain} = 4'h0;
    {redundantChains, opts, tableOptBits, faults} = 15'h0000;
    {rangeStartReg, rangeEndReg} = 32'h00000000;
    ackDelay = 4'h1;
    do_reset();
    cyc(4);
    chk(cpu1Lamp && !cpu2Lamp && relayCoil === 12'h000, "cpu1");
    cpu2Select = 1'h1;
    cyc(5);
    chk(!cpu1Lamp && cpu2Lamp && relayCoil === 12'hFFF, "cpu2");
    backupBitSelect = 1'h1;
    cyc(2);
    chk(backupPoint === rdsc_pkg::ALTERNATE_BACKUP_INPUT, "alt pt");
    backupBitSelect = 1'h0;
    cpu2Select = 1'h0;
    cyc(5);
    chk(backupPoint === rdsc_pkg::DEFAULT_BACKUP_INPUT, "def pt");
    chk(cpu1Lamp && relayCoil === 12'h000, "back to cpu1");
    run(1'h1, 1'h0, 0, '{IN, TB});
    opts = 4'h7;
    {rangeStartReg, rangeEndReg} = {16'h000A, 16'h0014};
    run(1'h1, 1'h0, 0, '{IN, TB, OT, TR, RNG, RET});
    rangeEndReg = 16'h0009;
    run(1'h1, 1'h0, 0, '{IN, TB, OT, TR, RET});
    opts = 4'h0;
    tableOptBits = 4'h4;
    run(1'h1, 1'h0, 0, '{IN, TB, OT, TR});
    tableOptBits = 4'h8;
    ackDelay = 4'h7;
    run(1'h0, 1'h1, 0, '{IN, TB, OT, TR, OV, FULL});
    tableOptBits = 4'h0;
    run(1'h0, 1'h1, 0, '{IN, TB});
    ackDelay = 4'h0;
    run(1'h1, 1'h0, 3, '{IN, TB, IN, TB});
    run(1'h1, 1'h1, 0, '{IN, TB, IN, TB});
    wd(4'h0, 120, 1'h0);
    wd(4'h1, 33, 1'h0);
    wd(4'h1, 60, 1'h1);
    wd(4'h5, 50, 1'h0);
    wd(4'h5, 75, 1'h1);
    wd(4'h2, 60, 1'h1);
    wd(4'h8, 60, 1'h1);
    {processorFail, scanLimitSelect, faults[1], runHoldHold} = 4'h0;
    do_reset();
    for (int i = 0; i < 10; i++) begin
      {faults, auxChain, redundantChains} = (i < 4) ? 8'(i) : 8'h1 << (i - 2);
      sweepTick = 1'h1;
      cyc(1);
      sweepTick = 1'h0;
      cyc(3);
      chk(statusDigit === 4'(i) && statusSeg === SEG[i], "digit");
    end
    close_out();
  end

  // the whole run needs about 1000 cycles
  initial begin
    #(40 * 8000);
    fails++;
    close_out();
  end
endmodule
